// >>> core/stoi_top.sv
// Transmit section, line and path overhead insertion for one STS-3c line.
// Assumes the serializer paces byte positions with a one-cycle request.
`timescale 1ns/10ps

module stoi_dcc #(
   parameter int SLOTS = 27,
   parameter int BITS = 24
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic byte_en,
   input wire logic frame_tick,
   input wire logic ser_in,
   output logic clk_out,
   output logic [71:0] hold
);
   localparam logic [7:0] SLOT_LAST = 8'(stoi_pkg::FRAME_BYTES / SLOTS - 1);
   localparam logic [8:0] NBITS = 9'(BITS);
   stoi_pkg::stoi_dcc_s st, n;
   always_comb begin
      n = st;
      n.s1 = ser_in;
      n.s2 = st.s1;
      if (frame_tick) begin
         n.used = 9'h000;
         n.hold = st.shift << (9'd72 - NBITS);
      end
      if (byte_en) begin
         n.slot = (st.slot == SLOT_LAST) ? 8'h00 : st.slot + 8'h01;
      end
      // Pulses fill the first slots of a frame; the remaining slots are gaps.
      if (byte_en && st.slot == 8'h00) begin
         n.clk = 1'b0;
      end
      if (byte_en && st.slot == 8'h00 &&
         (frame_tick || st.used < NBITS)) begin
         n.clk = 1'b1;
         n.shift = {st.shift[70:0], st.s2};
         n.used = n.used + 9'h001;
      end
      if (byte_en && st.slot == SLOT_LAST / 8'h02) begin
         n.clk = 1'b0;
      end
   end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= n;
      end
   end
   assign clk_out = st.clk;
   assign hold = st.hold;
endmodule : stoi_dcc

module stoi_top #(
   parameter logic [7:0] A1_VAL = 8'hf6,
   parameter logic [7:0] A2_VAL = 8'h28,
   parameter logic [7:0] J0_VAL = 8'h01
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire stoi_pkg::stoi_cpu_s cpu,
   output logic [7:0] cpu_rdata,
   input wire logic line_byte_req,
   output logic [7:0] line_data,
   output logic line_frame_start,
   output logic pl_req,
   input wire logic [7:0] pl_data,
   input wire logic line_bip_err,
   input wire logic path_bip_err,
   input wire logic line_defect_request_in,
   input wire logic section_dcc_serial_in,
   output logic section_dcc_clock_out,
   input wire logic line_dcc_serial_in,
   output logic line_dcc_clock_out
);
   stoi_pkg::stoi_st_s st, n;
   logic [71:0] sd_hold, ld_hold;
   logic ben, fs, soh, h3, pstf, spe, j1, poh;
   logic [3:0] prow;
   logic [9:0] pw;
   logic [7:0] d;
   logic [14:0] sk;

   function automatic logic [7:0] pick(logic [71:0] h, logic [3:0] i);
      pick = h[{4'd8 - i, 3'b000} +: 8];
   endfunction : pick

   function automatic logic [3:0] third(logic [8:0] c);
      third = (c == 9'd0) ? 4'd0 : (c == 9'd3) ? 4'd1 : 4'd2;
   endfunction : third

   function automatic logic [14:0] scr_step(logic [6:0] s);
      logic [6:0] t;
      logic [7:0] k;
      t = s;
      k = 8'h00;
      for (int b = 7; b >= 0; b--) begin
         k[b] = t[6];
         t = {t[5:0], t[6] ^ t[5]};
      end
      scr_step = {t, k};
   endfunction : scr_step

   stoi_dcc #(.SLOTS(stoi_pkg::SD_SLOTS), .BITS(stoi_pkg::SD_BITS)) u_sd (
      .ref_clk(ref_clk), .resetn(resetn), .byte_en(ben), .frame_tick(fs),
      .ser_in(section_dcc_serial_in), .clk_out(section_dcc_clock_out),
      .hold(sd_hold));
   stoi_dcc #(.SLOTS(stoi_pkg::LD_SLOTS), .BITS(stoi_pkg::LD_BITS)) u_ld (
      .ref_clk(ref_clk), .resetn(resetn), .byte_en(ben), .frame_tick(fs),
      .ser_in(line_dcc_serial_in), .clk_out(line_dcc_clock_out),
      .hold(ld_hold));

   assign ben = line_byte_req;
   assign fs = ben && st.row == 4'd0 && st.col == 9'd0;
   assign soh = st.row < 4'd3 && st.col < stoi_pkg::TOH_W;
   assign h3 = st.row == 4'd3 && st.col >= 9'd6 && st.col < 9'd9;
   assign pstf = st.row == 4'd3 && st.col >= 9'd9 && st.col < 9'd12;
   assign spe = ben && ((st.col >= stoi_pkg::TOH_W &&
      !(st.just == stoi_pkg::JUST_POS && pstf)) ||
      (st.just == stoi_pkg::JUST_NEG && h3));
   assign j1 = spe && st.spe_cnt == 12'({st.ptr, 1'b0}) + 12'(st.ptr);
   assign poh = j1 || (spe && st.poh_on && st.poh_cnt == stoi_pkg::POH_GAP);
   assign prow = j1 ? 4'd0 : st.poh_row + 4'd1;
   assign pw = st.ptr ^ ((st.just == stoi_pkg::JUST_POS) ? stoi_pkg::I_MASK :
      (st.just == stoi_pkg::JUST_NEG) ? stoi_pkg::D_MASK : 10'h000);
   assign sk = scr_step(st.scr);
   assign pl_req = spe;

   always_comb begin
      n = st;
      n.s1 = line_defect_request_in;
      n.s2 = st.s1;
      d = spe ? pl_data : 8'h00;
      if (path_bip_err && st.pfebe_acc < stoi_pkg::FEBE_CAP) begin
         n.pfebe_acc = st.pfebe_acc + 4'd1;
      end
      if (line_bip_err && st.lfebe_acc < stoi_pkg::LFEBE_CAP) begin
         n.lfebe_acc = st.lfebe_acc + 8'd1;
      end
      if (fs) begin
         n.ais_act = st.sctl[stoi_pkg::S_AIS];
         n.pfebe_hold = st.pctl[stoi_pkg::P_FEBE] ? stoi_pkg::FEBE_CAP :
            st.pfebe_acc;
         n.pfebe_acc = {3'b000, path_bip_err};
         n.lfebe_hold = st.lfebe_acc;
         n.lfebe_acc = {7'h00, line_bip_err};
         n.ndf = 1'b0;
         n.just = stoi_pkg::JUST_NONE;
         if (st.just == stoi_pkg::JUST_POS && st.ptr <= stoi_pkg::PTR_MAX) begin
            n.ptr = (st.ptr == stoi_pkg::PTR_MAX) ? 10'd0 : st.ptr + 10'd1;
         end
         if (st.just == stoi_pkg::JUST_NEG && st.ptr <= stoi_pkg::PTR_MAX) begin
            n.ptr = (st.ptr == 10'd0) ? stoi_pkg::PTR_MAX : st.ptr - 10'd1;
         end
         if (st.pctl[stoi_pkg::P_LOAD]) begin
            n.ptr = st.pprog;
            n.ndf = st.pctl[stoi_pkg::P_NDF];
            n.pctl[stoi_pkg::P_LOAD] = 1'b0;
         end else if (st.pctl[stoi_pkg::P_PJ]) begin
            n.just = stoi_pkg::JUST_POS;
            n.pctl[stoi_pkg::P_PJ] = 1'b0;
         end else if (st.pctl[stoi_pkg::P_NJ]) begin
            n.just = stoi_pkg::JUST_NEG;
            n.pctl[stoi_pkg::P_NJ] = 1'b0;
         end
         if (st.pctl[stoi_pkg::P_NDFONLY]) begin
            n.ndf = 1'b1;
            n.pctl[stoi_pkg::P_NDFONLY] = 1'b0;
         end
      end
      if (ben) begin
         n.col = (st.col == stoi_pkg::COL_LAST) ? 9'd0 : st.col + 9'd1;
         n.lane = (st.lane == 2'd2) ? 2'd0 : st.lane + 2'd1;
         if (st.col == stoi_pkg::COL_LAST) begin
            n.row = (st.row == stoi_pkg::ROW_LAST) ? 4'd0 : st.row + 4'd1;
         end
         if (st.row == 4'd3 && st.col == 9'd8) begin
            n.spe_cnt = 12'h000;
         end
      end
      if (spe) begin
         n.spe_cnt = st.spe_cnt + 12'h001;
         n.poh_cnt = st.poh_cnt + 9'd1;
      end
      if (poh) begin
         n.poh_cnt = 9'd0;
         n.poh_row = prow;
         n.poh_on = prow < stoi_pkg::ROW_LAST;
      end
      if (ben && st.col < stoi_pkg::TOH_W && st.lane == 2'd0) begin
         unique case (st.row)
            4'd1: d = st.col == 9'd0 ? st.b1_hold ^
               {8{st.sctl[stoi_pkg::S_B1ERR]}} : 8'h00;
            4'd2: d = st.sctl[stoi_pkg::S_SDCC] ?
               pick(sd_hold, third(st.col)) : 8'h00;
            4'd4: d = st.col == 9'd3 ? (st.lctl[stoi_pkg::L_APS] ? st.k1 :
               8'h00) : st.col == 9'd6 ? d : 8'h00;
            4'd5, 4'd6, 4'd7: d = st.lctl[stoi_pkg::L_LDCC] ? pick(ld_hold,
               4'(3 * (st.row - 4'd5)) + third(st.col)) : 8'h00;
            default: d = d;
         endcase
      end
      if (ben && st.row == 4'd4 && st.col == 9'd6) begin
         d = st.lctl[stoi_pkg::L_APS] ? st.k2 : 8'h00;
         if (st.s2 || st.lctl[stoi_pkg::L_RDI]) begin
            d[2:0] = stoi_pkg::RDI_CODE;
         end
      end
      if (ben && st.row == 4'd0 && st.col < stoi_pkg::TOH_W) begin
         d = (st.col < 9'd3) ? A1_VAL : (st.col < 9'd6) ? A2_VAL :
            (st.col == 9'd6) ? J0_VAL : 8'(st.col - 9'd5);
         if (st.col < 9'd3 && st.sctl[stoi_pkg::S_FRMERR]) begin
            d[0] = ~d[0];
         end
      end
      if (ben && st.row == 4'd3 && st.col < 9'd6) begin
         unique case (st.col)
            9'd0: d = {st.ndf ? stoi_pkg::NDF_NEW : stoi_pkg::NDF_NORM,
               2'b00, pw[9:8]};
            9'd3: d = pw[7:0];
            9'd1, 9'd2: d = stoi_pkg::CONC_H1;
            default: d = stoi_pkg::CONC_H2;
         endcase
      end
      if (ben && st.row == 4'd4 && st.col < 9'd3) begin
         d = st.b2_hold[{st.lane, 3'b000} +: 8] ^
            {8{st.lctl[stoi_pkg::L_B2ERR]}};
      end
      if (ben && st.row == stoi_pkg::ROW_LAST && st.col == 9'd8) begin
         d = st.lfebe_hold;
      end
      if (poh && prow == 4'd1) begin
         d = st.b3_hold ^ {8{st.pctl[stoi_pkg::P_B3ERR]}};
      end
      if (poh && prow == 4'd3) begin
         d = {st.pfebe_hold, pl_data[3:0]};
      end
      if (j1) begin
         n.b3_hold = st.b3_acc;
         n.b3_acc = d;
      end else if (spe) begin
         n.b3_acc = st.b3_acc ^ d;
      end
      if (st.ais_act && !soh) begin
         d = 8'hff;
      end
      if (fs) begin
         n.b2_hold = st.b2_acc;
         n.b2_acc = 24'h000000;
      end else if (ben && !soh) begin
         n.b2_acc[{st.lane, 3'b000} +: 8] = st.b2_acc[{st.lane, 3'b000} +: 8]
            ^ d;
      end
      if (ben && !(st.row == 4'd0 && st.col < stoi_pkg::TOH_W)) begin
         n.scr = sk[14:8];
         if (st.sctl[stoi_pkg::S_SCR]) begin
            d = d ^ sk[7:0];
         end
      end
      if (ben && st.row == 4'd0 && st.col == 9'd8) begin
         n.scr = stoi_pkg::SCR_SEED;
      end
      if (fs) begin
         n.b1_hold = st.b1_acc;
         n.b1_acc = d;
      end else if (ben) begin
         n.b1_acc = st.b1_acc ^ d;
      end
      if (st.sctl[stoi_pkg::S_ZERO]) begin
         d = 8'h00;
      end
      if (ben) begin
         n.odata = d;
      end
      n.ofs = fs;
      if (cpu.wr) begin
         unique case (cpu.addr)
            stoi_pkg::SECT_CTL_ADDR: n.sctl = cpu.wdata;
            stoi_pkg::LINE_CTL_ADDR: n.lctl = cpu.wdata;
            stoi_pkg::K1_ADDR: n.k1 = cpu.wdata;
            stoi_pkg::K2_ADDR: n.k2 = cpu.wdata;
            stoi_pkg::PATH_CTL_ADDR: n.pctl = cpu.wdata;
            stoi_pkg::PTR_LO_ADDR: n.pprog[7:0] = cpu.wdata;
            stoi_pkg::PTR_HI_ADDR: n.pprog[9:8] = cpu.wdata[1:0];
            default: n.pprog = n.pprog;
         endcase
      end
      if (cpu.rd) begin
         unique case (cpu.addr)
            stoi_pkg::SECT_CTL_ADDR: n.rdata = st.sctl;
            stoi_pkg::LINE_CTL_ADDR: n.rdata = st.lctl;
            stoi_pkg::K1_ADDR: n.rdata = st.k1;
            stoi_pkg::K2_ADDR: n.rdata = st.k2;
            stoi_pkg::PATH_CTL_ADDR: n.rdata = st.pctl;
            stoi_pkg::PTR_LO_ADDR: n.rdata = st.pprog[7:0];
            stoi_pkg::PTR_HI_ADDR: n.rdata = {6'h00, st.pprog[9:8]};
            stoi_pkg::CUR_LO_ADDR: n.rdata = st.ptr[7:0];
            stoi_pkg::CUR_HI_ADDR: n.rdata = {6'h00, st.ptr[9:8]};
            default: n.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
         st.ptr <= stoi_pkg::PTR_RESET;
         st.pprog <= stoi_pkg::PTR_RESET;
         st.scr <= stoi_pkg::SCR_SEED;
      end else begin
         st <= n;
      end
   end

   assign cpu_rdata = st.rdata;
   assign line_data = st.odata;
   assign line_frame_start = st.ofs;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   logic plain;
   assign plain = !st.sctl[stoi_pkg::S_SCR] && !st.sctl[stoi_pkg::S_ZERO];
   sequence s_pos_frame;
      fs && st.just == stoi_pkg::JUST_POS && st.ptr < stoi_pkg::PTR_MAX;
   endsequence
   a_ais_frame_sync: assert property ($changed(st.ais_act) |-> $past(fs))
      else $error("alarm enable changed inside a frame");
   a_ais_ones_out: assert property (ben && st.ais_act && !soh && plain
      |=> line_data == 8'hff) else $error("alarm byte not all ones");
   a_zero_force: assert property (ben && st.sctl[stoi_pkg::S_ZERO]
      |=> line_data == 8'h00) else $error("zero force missed");
   a_a1_written: assert property (fs && !st.sctl[stoi_pkg::S_FRMERR] &&
      !st.sctl[stoi_pkg::S_ZERO] |=> line_data == A1_VAL && line_frame_start)
      else $error("framing byte wrong");
   a_conc_h1: assert property (ben && st.row == 4'd3 && st.col == 9'd1 &&
      plain && !st.ais_act |=> line_data == stoi_pkg::CONC_H1)
      else $error("concatenation byte wrong");
   a_ptr_increment: assert property (s_pos_frame |=>
      st.ptr == $past(st.ptr) + 10'd1 && st.just != stoi_pkg::JUST_POS)
      else $error("positive stuff pointer wrong");
   a_ptr_decrement: assert property (fs && st.just == stoi_pkg::JUST_NEG &&
      st.ptr > 10'd0 && st.ptr <= stoi_pkg::PTR_MAX
      |=> st.ptr == $past(st.ptr) - 10'd1)
      else $error("negative stuff pointer wrong");
   a_rdi_code: assert property (ben && st.row == 4'd4 && st.col == 9'd6 &&
      st.lctl[stoi_pkg::L_RDI] && plain && !st.ais_act
      |=> line_data[2:0] == stoi_pkg::RDI_CODE)
      else $error("remote defect code missing");
   a_febe_capped: assert property (st.pfebe_hold <= stoi_pkg::FEBE_CAP)
      else $error("path error count above cap");
endmodule : stoi_top

// >>> core/stoi_pkg.sv
// Constants, carriers and state layouts of the transmit overhead chain.
// Assumes one byte clock domain and byte positions paced by the serializer.
package stoi_pkg;
   localparam logic [7:0] SECT_CTL_ADDR = 8'h14;
   localparam logic [7:0] LINE_CTL_ADDR = 8'h15;
   localparam logic [7:0] K1_ADDR = 8'h16;
   localparam logic [7:0] K2_ADDR = 8'h17;
   localparam logic [7:0] PATH_CTL_ADDR = 8'h18;
   localparam logic [7:0] PTR_LO_ADDR = 8'h19;
   localparam logic [7:0] PTR_HI_ADDR = 8'h1a;
   localparam logic [7:0] CUR_LO_ADDR = 8'h1b;
   localparam logic [7:0] CUR_HI_ADDR = 8'h1c;
   localparam int S_AIS = 0, S_SDCC = 1, S_B1ERR = 2, S_FRMERR = 3;
   localparam int S_SCR = 4, S_ZERO = 5;
   localparam int L_APS = 0, L_LDCC = 1, L_B2ERR = 2, L_RDI = 3;
   localparam int P_B3ERR = 0, P_PJ = 1, P_NJ = 2, P_NDF = 3;
   localparam int P_NDFONLY = 4, P_FEBE = 5, P_LOAD = 6;
   localparam logic [8:0] COL_LAST = 9'd269;
   localparam logic [8:0] TOH_W = 9'd9;
   localparam logic [3:0] ROW_LAST = 4'd8;
   localparam logic [9:0] PTR_MAX = 10'd782;
   localparam logic [9:0] PTR_RESET = 10'h000;
   localparam logic [3:0] NDF_NORM = 4'h6;
   localparam logic [3:0] NDF_NEW = 4'h9;
   localparam logic [7:0] CONC_H1 = 8'h93;
   localparam logic [7:0] CONC_H2 = 8'hff;
   localparam logic [9:0] I_MASK = 10'h2aa;
   localparam logic [9:0] D_MASK = 10'h155;
   localparam logic [2:0] RDI_CODE = 3'h6;
   localparam logic [3:0] FEBE_CAP = 4'h8;
   localparam logic [7:0] LFEBE_CAP = 8'hff;
   localparam logic [6:0] SCR_SEED = 7'h7f;
   localparam logic [8:0] POH_GAP = 9'd260;
   localparam int FRAME_BYTES = 2430;
   localparam int FRAME_HZ = 8000;
   localparam int SDCC_CLK_HZ = 216000;
   localparam int SDCC_AVG_HZ = 192000;
   localparam int LDCC_CLK_HZ = 2160000;
   localparam int LDCC_AVG_HZ = 576000;
   localparam int SD_SLOTS = SDCC_CLK_HZ / FRAME_HZ;
   localparam int SD_BITS = SDCC_AVG_HZ / FRAME_HZ;
   localparam int LD_SLOTS = LDCC_CLK_HZ / FRAME_HZ;
   localparam int LD_BITS = LDCC_AVG_HZ / FRAME_HZ;
   typedef enum logic [1:0] {JUST_NONE, JUST_POS, JUST_NEG} stoi_just_e;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } stoi_cpu_s;
   typedef struct packed {
      logic s1, s2, clk;
      logic [7:0] slot;
      logic [8:0] used;
      logic [71:0] shift, hold;
   } stoi_dcc_s;
   typedef struct packed {
      logic s1, s2;
      logic [3:0] row;
      logic [8:0] col;
      logic [1:0] lane;
      logic ais_act;
      logic [6:0] scr;
      logic [7:0] b1_acc, b1_hold, b3_acc, b3_hold;
      logic [23:0] b2_acc, b2_hold;
      logic [11:0] spe_cnt;
      logic [8:0] poh_cnt;
      logic [3:0] poh_row;
      logic poh_on;
      logic [9:0] ptr, pprog;
      stoi_just_e just;
      logic ndf;
      logic [3:0] pfebe_acc, pfebe_hold;
      logic [7:0] lfebe_acc, lfebe_hold;
      logic [7:0] sctl, lctl, k1, k2, pctl, rdata, odata;
      logic ofs;
   } stoi_st_s;
endpackage : stoi_pkg

// >>> sim/stoi_line_model.sv
// Line serializer and serial channel sources beside the overhead chain.
// Assumes a registered output byte one cycle after each byte request.
`timescale 1ns/10ps
module stoi_line_model (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic slow,
   input wire logic [7:0] line_data,
   input wire logic line_frame_start,
   input wire logic section_dcc_clock_out,
   input wire logic line_dcc_clock_out,
   output logic line_byte_req,
   output logic section_dcc_serial_in,
   output logic line_dcc_serial_in
);
   localparam logic [23:0] SD_PAT = 24'ha53c0f;
   localparam logic [71:0] LD_PAT = 72'hc35a96e10f7721843b;
   logic got = 1'b0;
   logic tog = 1'b0;
   logic bank = 1'b0;
   logic sd_q = 1'b0;
   logic ld_q = 1'b0;
   logic [7:0] frm [2][2430];
   logic [7:0] b1_acc = 8'h00;
   logic [7:0] b1_last = 8'h00;
   logic [7:0] b2_acc [3] = '{default: 8'h00};
   logic [7:0] b2_last [3] = '{default: 8'h00};
   int pos = 0, nfrm = 0, sd_i = 0, ld_i = 0;
   int sd_cnt = 0, ld_cnt = 0, sd_last = 0, ld_last = 0;
   initial begin
      line_byte_req = 1'b0;
      section_dcc_serial_in = SD_PAT[23];
      line_dcc_serial_in = LD_PAT[71];
   end
   // Requests go out every cycle, or every other cycle when slow.
   always @(negedge ref_clk) begin
      tog = ~tog;
      line_byte_req <= resetn && (!slow || tog);
   end
   // Captures each frame into alternate banks and sums its parity.
   always @(posedge ref_clk) begin
      if (!resetn) begin
         got <= 1'b0;
         pos = 0;
         nfrm = 0;
         sd_i = 0;
         ld_i = 0;
         section_dcc_serial_in <= SD_PAT[23];
         line_dcc_serial_in <= LD_PAT[71];
      end else begin
         got <= line_byte_req;
         sd_q <= section_dcc_clock_out;
         ld_q <= line_dcc_clock_out;
         if (got && line_frame_start) begin
            b1_last = b1_acc;
            b2_last = b2_acc;
            sd_last = sd_cnt;
            ld_last = ld_cnt;
            b1_acc = 8'h00;
            b2_acc = '{default: 8'h00};
            sd_cnt = 0;
            ld_cnt = 0;
            pos = 0;
            bank = ~bank;
            nfrm++;
         end
         if (section_dcc_clock_out && !sd_q) sd_cnt++;
         if (line_dcc_clock_out && !ld_q) ld_cnt++;
         if (got && pos < 2430) begin
            frm[bank][pos] = line_data;
            b1_acc ^= line_data;
            if (pos >= 810 || pos % 270 >= 9) b2_acc[pos % 3] ^= line_data;
            pos++;
         end
         // The next bit is presented while the gapped clock is low.
         if (!section_dcc_clock_out && sd_q) begin
            sd_i = (sd_i + 1) % 24;
            section_dcc_serial_in <= SD_PAT[23 - sd_i];
         end
         if (!line_dcc_clock_out && ld_q) begin
            ld_i = (ld_i + 1) % 72;
            line_dcc_serial_in <= LD_PAT[71 - ld_i];
         end
      end
   end
endmodule : stoi_line_model

// >>> sim/tb_stoi_top.sv
// Self-checking bench for the transmit overhead chain.
// Assumes the line model paces bytes and feeds both serial channels.
`timescale 1ns/10ps
module tb_stoi_top;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic slow = 1'b1;
   logic line_defect_request_in = 1'b0;
   logic line_err = 1'b0;
   logic path_err = 1'b0;
   logic [7:0] pl_data = 8'h5a;
   stoi_pkg::stoi_cpu_s cpu = '0;
   logic [7:0] cpu_rdata, line_data, rv, e1;
   logic [7:0] e2 [3];
   logic [9:0] pv [2] = '{10'h3e8, 10'h064};
   logic line_byte_req, line_frame_start, pl_req;
   logic sd_in, sd_clk, ld_in, ld_clk;
   int failures = 0;
   int total_checks = 0;
   int cycles = 0;

   stoi_top u_dut (
      .ref_clk(ref_clk), .resetn(resetn), .cpu(cpu), .cpu_rdata(cpu_rdata),
      .line_byte_req(line_byte_req), .line_data(line_data),
      .line_frame_start(line_frame_start), .pl_req(pl_req),
      .pl_data(pl_data), .line_bip_err(line_err), .path_bip_err(path_err),
      .line_defect_request_in(line_defect_request_in),
      .section_dcc_serial_in(sd_in), .section_dcc_clock_out(sd_clk),
      .line_dcc_serial_in(ld_in), .line_dcc_clock_out(ld_clk)
   );
   stoi_line_model u_line (
      .ref_clk(ref_clk), .resetn(resetn), .slow(slow),
      .line_data(line_data), .line_frame_start(line_frame_start),
      .section_dcc_clock_out(sd_clk), .line_dcc_clock_out(ld_clk),
      .line_byte_req(line_byte_req), .section_dcc_serial_in(sd_in),
      .line_dcc_serial_in(ld_in)
   );

   always #10 ref_clk = ~ref_clk;

   task automatic tally_and_finish();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 95000) begin
         failures++;
         $display("[ERR] run length expected below 95000 got %0d", cycles);
         tally_and_finish();
      end
   end

   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h got %h", n, e, g);
      end
   endtask : chk8

   task automatic chkn(input string n, input int e, input int g);
      total_checks++;
      if (g != e) begin
         failures++;
         $display("[ERR] %s expected %0d got %0d", n, e, g);
      end
   endtask : chkn

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      cpu.wr = 1'b1;
      cpu.addr = a;
      cpu.wdata = d;
      @(negedge ref_clk);
      cpu.wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      cpu.rd = 1'b1;
      cpu.addr = a;
      @(negedge ref_clk);
      cpu.rd = 1'b0;
      d = cpu_rdata;
   endtask : rd

   task automatic frames(input int n);
      int f0;
      f0 = u_line.nfrm;
      for (int i = 0; i < 12000 * n && u_line.nfrm < f0 + n; i++) begin
         @(posedge ref_clk);
      end
      @(negedge ref_clk);
   endtask : frames

   function automatic logic [7:0] fb(input int r, input int c);
      return u_line.frm[~u_line.bank][r * 270 + c];
   endfunction : fb

   function automatic logic [7:0] scr_at(input int n);
      logic [6:0] s;
      logic [7:0] b;
      s = 7'h7f;
      b = 8'h00;
      for (int i = 0; i < 8 * n + 8; i++) begin
         b = {b[6:0], s[6]};
         s = {s[5:0], s[6] ^ s[5]};
      end
      return b;
   endfunction : scr_at

   task automatic chk_ptr(input logic [3:0] f, input logic [9:0] v);
      chk8("pointer first byte", {f, 2'b00, v[9:8]}, fb(3, 0));
      chk8("pointer second byte", v[7:0], fb(3, 3));
   endtask : chk_ptr

   initial begin
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      resetn = 1'b1;
      wr(stoi_pkg::SECT_CTL_ADDR, 8'h02);
      wr(stoi_pkg::LINE_CTL_ADDR, 8'h02);
      rd(stoi_pkg::CUR_LO_ADDR, rv);
      chk8("current pointer after reset", 8'h00, rv);
      wr(stoi_pkg::K1_ADDR, 8'h3c);
      rd(stoi_pkg::K1_ADDR, rv);
      chk8("k1 readback", 8'h3c, rv);
      rd(8'h30, rv);
      chk8("unmapped read", 8'h00, rv);
      frames(1);
      slow = 1'b0;
      frames(3);
      for (int i = 0; i < 3; i++) begin
         chk8("a1", 8'hf6, fb(0, i));
         chk8("a2", 8'h28, fb(0, 3 + i));
      end
      chk8("j0", 8'h01, fb(0, 6));
      chk_ptr(stoi_pkg::NDF_NORM, 10'h000);
      for (int i = 1; i < 3; i++) begin
         chk8("concat first", stoi_pkg::CONC_H1, fb(3, i));
         chk8("concat second", stoi_pkg::CONC_H2, fb(3, 3 + i));
      end
      chk8("payload", 8'h5a, fb(5, 100));
      chkn("section clock pulses", 24, u_line.sd_last);
      chkn("line clock pulses", 72, u_line.ld_last);
      chk8("section channel 1", 8'ha5, fb(2, 0));
      chk8("section channel 2", 8'h3c, fb(2, 3));
      chk8("section channel 3", 8'h0f, fb(2, 6));
      chk8("line channel 1", 8'hc3, fb(5, 0));
      for (int i = 0; i < 10; i++) begin
         @(negedge ref_clk);
         path_err = 1'b1;
         line_err = i < 3;
         @(negedge ref_clk);
         path_err = 1'b0;
         line_err = 1'b0;
      end
      frames(2);
      chk8("path error count", {stoi_pkg::FEBE_CAP, 4'ha}, fb(6, 9));
      chk8("line error count", 8'h03, fb(8, 8));
      e1 = u_line.b1_last;
      e2 = u_line.b2_last;
      frames(1);
      chk8("section parity", e1, fb(1, 0));
      for (int i = 0; i < 3; i++) chk8("line parity", e2[i], fb(4, i));
      wr(stoi_pkg::SECT_CTL_ADDR, 8'h06);
      wr(stoi_pkg::LINE_CTL_ADDR, 8'h06);
      frames(1);
      e1 = u_line.b1_last;
      e2 = u_line.b2_last;
      frames(1);
      chkn("section parity corrupted", 1, fb(1, 0) !== e1);
      chkn("line parity corrupted", 1, fb(4, 0) !== e2[0]);
      for (int i = 0; i < 2; i++) begin
         wr(stoi_pkg::SECT_CTL_ADDR, i ? 8'h20 : 8'h08);
         frames(2);
         chk8("a1 diagnostic", i ? 8'h00 : 8'hf7, fb(0, 0));
         chk8("payload diagnostic", i ? 8'h00 : 8'h5a, fb(5, 100));
      end
      wr(stoi_pkg::SECT_CTL_ADDR, 8'h01);
      frames(1);
      chk8("alarm same frame", 8'h5a, fb(8, 100));
      frames(1);
      chk8("alarm payload", 8'hff, fb(8, 100));
      chk8("alarm line overhead", 8'hff, fb(4, 3));
      chk8("alarm a1", 8'hf6, fb(0, 0));
      wr(stoi_pkg::SECT_CTL_ADDR, 8'h00);
      frames(1);
      chk8("alarm held to frame end", 8'hff, fb(8, 100));
      wr(stoi_pkg::SECT_CTL_ADDR, 8'h11);
      frames(2);
      chk8("scrambled ones", 8'hff ^ scr_at(821), fb(3, 20));
      chk8("a1 unscrambled", 8'hf6, fb(0, 0));
      chk8("j0 unscrambled", 8'h01, fb(0, 6));
      wr(stoi_pkg::SECT_CTL_ADDR, 8'h00);
      wr(stoi_pkg::K2_ADDR, 8'ha1);
      wr(stoi_pkg::LINE_CTL_ADDR, 8'h01);
      frames(2);
      chk8("k1 inserted", 8'h3c, fb(4, 3));
      chk8("k2 inserted", 8'ha1, fb(4, 6));
      wr(stoi_pkg::LINE_CTL_ADDR, 8'h09);
      frames(2);
      chk8("k2 defect by register", 8'ha6, fb(4, 6));
      wr(stoi_pkg::LINE_CTL_ADDR, 8'h01);
      line_defect_request_in = 1'b1;
      frames(2);
      chk8("k2 defect by pin", 8'ha6, fb(4, 6));
      line_defect_request_in = 1'b0;
      for (int i = 0; i < 2; i++) begin
         wr(stoi_pkg::PTR_LO_ADDR, pv[i][7:0]);
         wr(stoi_pkg::PTR_HI_ADDR, {6'h00, pv[i][9:8]});
         wr(stoi_pkg::PATH_CTL_ADDR, 8'h40);
         frames(2);
         chk_ptr(stoi_pkg::NDF_NORM, pv[i]);
      end
      wr(stoi_pkg::PATH_CTL_ADDR, 8'h10);
      frames(2);
      chk_ptr(stoi_pkg::NDF_NEW, 10'h064);
      wr(stoi_pkg::PATH_CTL_ADDR, 8'h02);
      frames(2);
      chk_ptr(stoi_pkg::NDF_NORM, 10'h064 ^ stoi_pkg::I_MASK);
      frames(1);
      chk_ptr(stoi_pkg::NDF_NORM, 10'h065);
      rd(stoi_pkg::CUR_LO_ADDR, rv);
      chk8("current pointer low", 8'h65, rv);
      rd(stoi_pkg::CUR_HI_ADDR, rv);
      chk8("current pointer high", 8'h00, rv);
      wr(stoi_pkg::PATH_CTL_ADDR, 8'h04);
      frames(2);
      chk_ptr(stoi_pkg::NDF_NORM, 10'h065 ^ stoi_pkg::D_MASK);
      frames(1);
      chk_ptr(stoi_pkg::NDF_NORM, 10'h064);
      resetn = 1'b0;
      repeat (2) @(negedge ref_clk);
      resetn = 1'b1;
      rd(stoi_pkg::CUR_LO_ADDR, rv);
      chk8("current pointer after second reset", 8'h00, rv);
      tally_and_finish();
   end
endmodule : tb_stoi_top
